//--- logic/fet_pkg.sv
// shared constants, types and helpers for the fine-edge timing generator
package fet_pkg;

  // pixel period split into edge positions
  localparam int unsigned         FET_PHASES     = 48;
  localparam int unsigned         FET_QUAD_STEPS = 12;
  localparam logic [5:0]          FET_LAST_PHASE = 6'h2F;
  localparam logic [3:0]          FET_MAX_OFFSET = 4'hB;

  // serial frame: 8 address bits then 8 data bits
  localparam logic [4:0]          FET_FRAME_BITS = 5'h10;

  // serial register addresses
  localparam logic [7:0]          FET_A_OPMODE_LO  = 8'h00;
  localparam logic [7:0]          FET_A_OPMODE_HI  = 8'h01;
  localparam logic [7:0]          FET_A_CTL_MODE   = 8'h06;
  localparam logic [7:0]          FET_A_HA_POL     = 8'hE5;
  localparam logic [7:0]          FET_A_HA_POS     = 8'hE6;
  localparam logic [7:0]          FET_A_HA_NEG     = 8'hE7;
  localparam logic [7:0]          FET_A_HA_DRV     = 8'hE8;
  localparam logic [7:0]          FET_A_HAI_DRV    = 8'hE9;
  localparam logic [7:0]          FET_A_HB_DRV     = 8'hEA;
  localparam logic [7:0]          FET_A_HBI_DRV    = 8'hEB;
  localparam logic [7:0]          FET_A_GATE_POL   = 8'hEC;
  localparam logic [7:0]          FET_A_GATE_POS   = 8'hED;
  localparam logic [7:0]          FET_A_GATE_NEG   = 8'hEE;
  localparam logic [7:0]          FET_A_GATE_DRV   = 8'hEF;
  localparam logic [7:0]          FET_A_REF_LOC    = 8'hF0;
  localparam logic [7:0]          FET_A_DAT_LOC    = 8'hF1;
  localparam logic [7:0]          FET_A_DOUT_PHASE = 8'hF2;
  localparam logic [7:0]          FET_A_HB_POL     = 8'hF3;
  localparam logic [7:0]          FET_A_HB_POS     = 8'hF4;
  localparam logic [7:0]          FET_A_HB_NEG     = 8'hF5;

  // reset values
  localparam logic [7:0]          FET_RST_OPMODE  = 8'h00;
  localparam logic [5:0]          FET_RST_CTL_MODE = 6'h00;
  localparam logic [5:0]          FET_RST_H_POS    = 6'h00;
  localparam logic [5:0]          FET_RST_H_NEG    = 6'h20;
  localparam logic [5:0]          FET_RST_GATE_POS = 6'h00;
  localparam logic [5:0]          FET_RST_GATE_NEG = 6'h10;
  localparam logic [5:0]          FET_RST_REF_LOC  = 6'h24;
  localparam logic [5:0]          FET_RST_DAT_LOC  = 6'h00;
  localparam logic [5:0]          FET_RST_DOUT     = 6'h00;
  localparam logic [2:0]          FET_RST_H_DRV    = 3'h3;
  localparam logic [2:0]          FET_RST_GATE_DRV = 3'h2;

  // operating-mode field positions
  localparam int unsigned         FET_OP_PWR_LSB   = 0;
  localparam int unsigned         FET_OP_CLAMP_DIS = 2;
  // control field positions
  localparam int unsigned         FET_CT_STEER_LSB = 0;
  localparam int unsigned         FET_CT_GAIN_EN   = 3;
  localparam int unsigned         FET_CT_LATCH_TR  = 4;
  localparam int unsigned         FET_CT_DOUT_HIZ  = 5;

  // number of driven outputs with a strength code
  localparam int unsigned         FET_NUM_DRV = 5;

  typedef enum logic [1:0] {
    FET_PWR_FULL     = 2'b00,
    FET_PWR_FAST_REC = 2'b01,
    FET_PWR_REF_STBY = 2'b10,
    FET_PWR_SHUTDOWN = 2'b11
  } fet_power_e;

  typedef enum logic [2:0] {
    FET_CS_OFF         = 3'b000,
    FET_CS_MOSAIC_SEP  = 3'b001,
    FET_CS_VSEL_INTERL = 3'b010,
    FET_CS_MOSAIC_REP  = 3'b011,
    FET_CS_THREE_COL   = 3'b100,
    FET_CS_THREE_COL2  = 3'b101,
    FET_CS_FOUR_COL    = 3'b110,
    FET_CS_FOUR_COL2   = 3'b111
  } fet_colour_e;

  // one programmable pulse: polarity plus two edge codes
  typedef struct packed {
    logic       pol;
    logic [5:0] pos;
    logic [5:0] neg;
  } fet_edge_cfg_s;

  // edge code is quadrant in [5:4], offset in [3:0]
  function automatic logic fet_code_valid(input logic [5:0] code);
    fet_code_valid = (code[3:0] <= FET_MAX_OFFSET);
  endfunction : fet_code_valid

  function automatic logic [5:0] fet_code_pos(input logic [5:0] code);
    logic [5:0] quad_base;
    quad_base    = 6'(code[5:4] * FET_QUAD_STEPS);
    fet_code_pos = quad_base + {2'h0, code[3:0]};
  endfunction : fet_code_pos

endpackage : fet_pkg

//--- logic/fet_edge_gen.sv
// one programmable pulse placed on the shared phase count
`timescale 1ns/10ps
module fet_edge_gen
  import fet_pkg::*;
(
  input  wire logic          ref_clk_i,
  input  wire logic          resetn_i,
  input  wire logic [5:0]    phase_i,
  input  wire fet_edge_cfg_s cfg_i,
  output logic               next_level_o
);

  logic rise_hit;
  logic fall_hit;
  logic level;

  // codes with offset above eleven never match any phase
  assign rise_hit = fet_code_valid(cfg_i.pos) && (fet_code_pos(cfg_i.pos) == phase_i); // R6 R22
  assign fall_hit = fet_code_valid(cfg_i.neg) && (fet_code_pos(cfg_i.neg) == phase_i); // R6 R22

  // unpolarised level, rising edge wins a tie
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      level <= 1'b0;
    else if (rise_hit)
      level <= 1'b1;
    else if (fall_hit)
      level <= 1'b0;
  end

  // value the owner registers on the next edge, polarity applied
  always_comb
  begin
    if (rise_hit)
      next_level_o = 1'b1 ^ cfg_i.pol; // R7
    else if (fall_hit)
      next_level_o = 1'b0 ^ cfg_i.pol; // R7
    else
      next_level_o = level ^ cfg_i.pol; // R7
  end

endmodule : fet_edge_gen

//--- logic/fet_timing_gen.sv
// fine-edge timing generator: 48-phase core, pulse placement, serial registers
// Functional notes
// (R1) each pixel period is split into 48 equal edge positions
// (R2) master clock must equal the sensor pixel clock; here a pixel period spans 48 ref_clk_i cycles
// (R3) reset-gate pulse has programmable rise and fall, and polarity inversion
// (R4) first and third horizontal clocks have programmable edges and polarity
// (R5) second and fourth horizontal clocks are inverses of first and third
// (R6) edge code: quadrant in bits 5:4, offset 0..11; position = quadrant*12+offset
// (R7) polarity bit 0 keeps, 1 inverts horizontal pair and reset gate
// (R8) reference and data sampling strobes each sit at their programmed position
// (R9) 3-bit drive code in 3.5 mA steps; 0 is high impedance
// (R10) output data launches at a programmed position 0..47
// (R11) operating mode bits 5:0 at address 0x00, bits 7:6 at 0x01
// (R12) power field: full, fast recovery, reference standby, shutdown
// (R13) operating mode bit 2 high disables black-level clamping
// (R14) software keeps test bits: bit 4 high, bits 3,5,6,7 low
// (R15) 3-bit colour steering selects one of eight steering modes
// (R16) control bit 3 high enables per-pixel gain steering
// (R17) control bit 4: 0 latch data on output phase, 1 transparent
// (R18) control bit 5: 0 drive data outputs, 1 high impedance
// (R19) reset gate defaults: rise code 00, fall code 10
// (R20) sampling defaults: reference code 24, data code 00
// (R21) software never writes edge codes with offset above 11
// (R22) all edges are placed on the one shared 48-phase count
`timescale 1ns/10ps
module fet_timing_gen
  import fet_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ser_clk_i,
  input  wire logic        ser_data_i,
  input  wire logic        ser_load_n_i,
  input  wire logic [11:0] adc_data_i,
  output logic             reset_gate_pulse_o,
  output logic             reset_gate_pulse_oe_o,
  output logic             horiz_clock_a_o,
  output logic             horiz_clock_a_oe_o,
  output logic             horiz_clock_a_inv_o,
  output logic             horiz_clock_a_inv_oe_o,
  output logic             horiz_clock_b_o,
  output logic             horiz_clock_b_oe_o,
  output logic             horiz_clock_b_inv_o,
  output logic             horiz_clock_b_inv_oe_o,
  output logic [2:0]       horiz_a_drive_o,
  output logic [2:0]       horiz_a_inv_drive_o,
  output logic [2:0]       horiz_b_drive_o,
  output logic [2:0]       horiz_b_inv_drive_o,
  output logic [2:0]       reset_gate_drive_o,
  output logic             reference_sample_strobe_o,
  output logic             data_sample_strobe_o,
  output logic             output_data_phase_o,
  output logic [11:0]      data_o,
  output logic             data_oe_o,
  output logic [1:0]       power_mode_o,
  output logic             clamp_disable_o,
  output logic [2:0]       colour_steer_o,
  output logic             gain_steer_en_o
);

  // phase count and serial port state
  logic [5:0]          phase;
  logic                ser_clk_q;
  logic                ser_load_q;
  logic [15:0]         ser_shift;
  logic [4:0]          ser_count;
  logic                wr_en;
  logic [7:0]          wr_addr;
  logic [7:0]          wr_data;

  // programmed state
  logic [7:0]          op_mode;
  logic [5:0]          ctl_mode;
  fet_edge_cfg_s       gate_cfg;
  fet_edge_cfg_s       ha_cfg;
  fet_edge_cfg_s       hb_cfg;
  logic [5:0]          ref_loc;
  logic [5:0]          dat_loc;
  logic [5:0]          dout_phase;
  logic [2:0]          drv [FET_NUM_DRV];

  logic                next_gate;
  logic                next_ha;
  logic                next_hb;
  logic [FET_NUM_DRV-1:0] drv_level;

  // 48-step phase count, one step per clock
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      phase <= 6'h00;
    else if (phase == FET_LAST_PHASE) // R1
      phase <= 6'h00;
    else
      phase <= phase + 6'h01;
  end

  // serial pins sampled for edge detection
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      ser_clk_q  <= 1'b0;
      ser_load_q <= 1'b1;
    end
    else
    begin
      ser_clk_q  <= ser_clk_i;
      ser_load_q <= ser_load_n_i;
    end
  end

  // shift in address then data, lsb first, while load is low
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      ser_shift <= 16'h0000;
      ser_count <= 5'h00;
    end
    else if (ser_load_n_i)
      ser_count <= 5'h00;
    else if (ser_clk_i && !ser_clk_q && ser_count != FET_FRAME_BITS)
    begin
      ser_shift <= {ser_data_i, ser_shift[15:1]};
      ser_count <= ser_count + 5'h01;
    end
  end

  // a whole frame commits on the rising edge of load
  assign wr_en   = ser_load_n_i && !ser_load_q && (ser_count == FET_FRAME_BITS);
  assign wr_addr = ser_shift[7:0];
  assign wr_data = ser_shift[15:8];

  // mode and control fields
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      op_mode  <= FET_RST_OPMODE;
      ctl_mode <= FET_RST_CTL_MODE;
    end
    else if (wr_en)
    begin
      if (wr_addr == FET_A_OPMODE_LO)
        op_mode[5:0] <= wr_data[5:0]; // R11
      if (wr_addr == FET_A_OPMODE_HI)
        op_mode[7:6] <= wr_data[1:0]; // R11
      if (wr_addr == FET_A_CTL_MODE)
        ctl_mode <= wr_data[5:0];
    end
  end

  // edge and strobe placement registers
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      gate_cfg   <= '{pol: 1'b0, pos: FET_RST_GATE_POS, neg: FET_RST_GATE_NEG}; // R19
      ha_cfg     <= '{pol: 1'b0, pos: FET_RST_H_POS, neg: FET_RST_H_NEG};
      hb_cfg     <= '{pol: 1'b0, pos: FET_RST_H_POS, neg: FET_RST_H_NEG};
      ref_loc    <= FET_RST_REF_LOC; // R20
      dat_loc    <= FET_RST_DAT_LOC; // R20
      dout_phase <= FET_RST_DOUT;
    end
    else if (wr_en)
    begin
      unique case (wr_addr)
        FET_A_GATE_POL:   gate_cfg.pol <= wr_data[0];
        FET_A_GATE_POS:   gate_cfg.pos <= wr_data[5:0];
        FET_A_GATE_NEG:   gate_cfg.neg <= wr_data[5:0];
        FET_A_HA_POL:     ha_cfg.pol <= wr_data[0];
        FET_A_HA_POS:     ha_cfg.pos <= wr_data[5:0];
        FET_A_HA_NEG:     ha_cfg.neg <= wr_data[5:0];
        FET_A_HB_POL:     hb_cfg.pol <= wr_data[0];
        FET_A_HB_POS:     hb_cfg.pos <= wr_data[5:0];
        FET_A_HB_NEG:     hb_cfg.neg <= wr_data[5:0];
        FET_A_REF_LOC:    ref_loc    <= wr_data[5:0];
        FET_A_DAT_LOC:    dat_loc    <= wr_data[5:0];
        FET_A_DOUT_PHASE: dout_phase <= wr_data[5:0];
        default:          ;
      endcase
    end
  end

  // drive strength per driven output, with its enable flop
  for (genvar i = 0; i < FET_NUM_DRV; i++)
  begin : g_drv
    localparam logic [7:0] DRV_ADDR = (i == 0) ? FET_A_HA_DRV :
                                      (i == 1) ? FET_A_HAI_DRV :
                                      (i == 2) ? FET_A_HB_DRV :
                                      (i == 3) ? FET_A_HBI_DRV : FET_A_GATE_DRV;
    localparam logic [2:0] DRV_RST  = (i == FET_NUM_DRV - 1) ? FET_RST_GATE_DRV : FET_RST_H_DRV;

    always_ff @(posedge ref_clk_i)
    begin
      if (!resetn_i)
        drv[i] <= DRV_RST;
      else if (wr_en && wr_addr == DRV_ADDR)
        drv[i] <= wr_data[2:0]; // R9
    end

    // code zero leaves the pin undriven
    always_ff @(posedge ref_clk_i)
    begin
      if (!resetn_i)
        drv_level[i] <= 1'b0;
      else
        drv_level[i] <= (drv[i] != 3'h0); // R9
    end
  end

  assign reset_gate_pulse_oe_o  = drv_level[4];
  assign horiz_clock_a_oe_o     = drv_level[0];
  assign horiz_clock_a_inv_oe_o = drv_level[1];
  assign horiz_clock_b_oe_o     = drv_level[2];
  assign horiz_clock_b_inv_oe_o = drv_level[3];
  assign horiz_a_drive_o        = drv[0];
  assign horiz_a_inv_drive_o    = drv[1];
  assign horiz_b_drive_o        = drv[2];
  assign horiz_b_inv_drive_o    = drv[3];
  assign reset_gate_drive_o     = drv[4];

  // pulse generators on the shared phase count
  fet_edge_gen u_gate (
    .ref_clk_i    (ref_clk_i),
    .resetn_i     (resetn_i),
    .phase_i      (phase),
    .cfg_i        (gate_cfg),
    .next_level_o (next_gate)
  ); // R3

  fet_edge_gen u_ha (
    .ref_clk_i    (ref_clk_i),
    .resetn_i     (resetn_i),
    .phase_i      (phase),
    .cfg_i        (ha_cfg),
    .next_level_o (next_ha)
  ); // R4

  fet_edge_gen u_hb (
    .ref_clk_i    (ref_clk_i),
    .resetn_i     (resetn_i),
    .phase_i      (phase),
    .cfg_i        (hb_cfg),
    .next_level_o (next_hb)
  ); // R4

  // clock outputs; inverses come from the same next value
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      reset_gate_pulse_o  <= 1'b0;
      horiz_clock_a_o     <= 1'b0;
      horiz_clock_a_inv_o <= 1'b1;
      horiz_clock_b_o     <= 1'b0;
      horiz_clock_b_inv_o <= 1'b1;
    end
    else
    begin
      reset_gate_pulse_o  <= next_gate; // R3
      horiz_clock_a_o     <= next_ha; // R4
      horiz_clock_a_inv_o <= ~next_ha; // R5
      horiz_clock_b_o     <= next_hb; // R4
      horiz_clock_b_inv_o <= ~next_hb; // R5
    end
  end

  // one-cycle sampling and output-phase strobes
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      reference_sample_strobe_o <= 1'b0;
      data_sample_strobe_o      <= 1'b0;
      output_data_phase_o       <= 1'b0;
    end
    else
    begin
      reference_sample_strobe_o <= fet_code_valid(ref_loc) && (fet_code_pos(ref_loc) == phase); // R8 R22
      data_sample_strobe_o      <= fet_code_valid(dat_loc) && (fet_code_pos(dat_loc) == phase); // R8 R22
      output_data_phase_o       <= (dout_phase == phase); // R10
    end
  end

  // converter data: latched at output phase or transparent
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
      data_o <= 12'h000;
    else if (ctl_mode[FET_CT_LATCH_TR]) // R17
      data_o <= adc_data_i;
    else if (dout_phase == phase) // R10 R17
      data_o <= adc_data_i;
  end

  // decoded mode and control outputs
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      data_oe_o       <= 1'b0;
      power_mode_o    <= FET_PWR_FULL;
      clamp_disable_o <= 1'b0;
      colour_steer_o  <= FET_CS_OFF;
      gain_steer_en_o <= 1'b0;
    end
    else
    begin
      data_oe_o       <= ~ctl_mode[FET_CT_DOUT_HIZ]; // R18
      power_mode_o    <= op_mode[FET_OP_PWR_LSB +: 2]; // R12
      clamp_disable_o <= op_mode[FET_OP_CLAMP_DIS]; // R13
      colour_steer_o  <= ctl_mode[FET_CT_STEER_LSB +: 3]; // R15
      gain_steer_en_o <= ctl_mode[FET_CT_GAIN_EN]; // R16
    end
  end

endmodule : fet_timing_gen

//--- test/fet_timing_gen_checker.sv
// port-level assertions for the fine-edge timing generator
`timescale 1ns/10ps
module fet_timing_gen_checker (
  input wire logic       ref_clk_i,
  input wire logic       resetn_i,
  input wire logic       ser_load_n_i,
  input wire logic       reset_gate_pulse_oe_o,
  input wire logic       horiz_clock_a_o,
  input wire logic       horiz_clock_a_oe_o,
  input wire logic       horiz_clock_a_inv_o,
  input wire logic       horiz_clock_b_o,
  input wire logic       horiz_clock_b_inv_o,
  input wire logic [2:0] horiz_a_drive_o,
  input wire logic [2:0] reset_gate_drive_o,
  input wire logic       reference_sample_strobe_o,
  input wire logic       data_sample_strobe_o,
  input wire logic       output_data_phase_o,
  input wire logic       clamp_disable_o,
  input wire logic [2:0] colour_steer_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  logic       load_q;
  logic       live;
  logic [6:0] quiet;
  // cycles since reset release or the last rise of load, whole frame or not
  always_ff @(posedge ref_clk_i)
  begin
    load_q <= ser_load_n_i;
    live   <= resetn_i;
    if (!resetn_i || (ser_load_n_i && !load_q))
      quiet <= 7'h00;
    else if (quiet != 7'h7F)
      quiet <= quiet + 7'h01;
  end
  a_inv_a_pair: assert property (horiz_clock_a_inv_o == !horiz_clock_a_o)
    else $error("inverse clock a is not the complement");
  a_inv_b_pair: assert property (horiz_clock_b_inv_o == !horiz_clock_b_o)
    else $error("inverse clock b is not the complement");
  a_gate_drive_oe: assert property (live |-> reset_gate_pulse_oe_o == ($past(reset_gate_drive_o) != 3'h0))
    else $error("reset gate enable does not follow its drive code");
  a_ha_drive_oe: assert property (live |-> horiz_clock_a_oe_o == ($past(horiz_a_drive_o) != 3'h0))
    else $error("clock a enable does not follow its drive code");
  a_ref_period: assert property (reference_sample_strobe_o && quiet > 7'h63 |-> $past(reference_sample_strobe_o, 48))
    else $error("reference strobe period is not 48 cycles");
  a_dat_period: assert property (data_sample_strobe_o && quiet > 7'h63 |-> $past(data_sample_strobe_o, 48))
    else $error("data strobe period is not 48 cycles");
  a_phase_period: assert property (output_data_phase_o && quiet > 7'h63 |-> $past(output_data_phase_o, 48))
    else $error("output phase period is not 48 cycles");
  a_ref_single: assert property (reference_sample_strobe_o |=> !reference_sample_strobe_o)
    else $error("reference strobe longer than one cycle");
  a_clamp_after_commit: assert property ($changed(clamp_disable_o) |-> $past(ser_load_n_i, 2) && !$past(ser_load_n_i, 3))
    else $error("clamp control moved without a frame commit");
  a_steer_after_commit: assert property ($changed(colour_steer_o) |-> $past(ser_load_n_i, 2) && !$past(ser_load_n_i, 3))
    else $error("colour steering moved without a frame commit");
endmodule : fet_timing_gen_checker

bind fet_timing_gen fet_timing_gen_checker fet_timing_gen_checker_i (
  .ref_clk_i, .resetn_i, .ser_load_n_i, .reset_gate_pulse_oe_o, .horiz_clock_a_o, .horiz_clock_a_oe_o,
  .horiz_clock_a_inv_o, .horiz_clock_b_o, .horiz_clock_b_inv_o, .horiz_a_drive_o, .reset_gate_drive_o,
  .reference_sample_strobe_o, .data_sample_strobe_o, .output_data_phase_o, .clamp_disable_o, .colour_steer_o
);

//--- test/fet_sensor_model.sv
// behavioural sensor end of the horizontal and reset-gate clocks
`timescale 1ns/10ps
module fet_sensor_model (
  input  wire logic        ref_clk_i,
  input  wire logic        ha_i,
  input  wire logic        ha_oe_i,
  input  wire logic        gate_i,
  input  wire logic        gate_oe_i,
  output logic      [15:0] shifts_o = 16'h0000,
  output logic      [15:0] resets_o = 16'h0000
);
  logic ha_w   = 1'b0;
  logic gate_w = 1'b0;
  logic ha_q   = 1'b0;
  logic gate_q = 1'b0;
  // released inputs wander away from the last driven level
  always @(posedge ref_clk_i)
  begin
    ha_w     <= ha_oe_i ? ha_i : ~ha_w;
    gate_w   <= gate_oe_i ? gate_i : ~gate_w;
    ha_q     <= ha_w;
    gate_q   <= gate_w;
    shifts_o <= shifts_o + 16'(ha_w & ~ha_q);
    resets_o <= resets_o + 16'(gate_w & ~gate_q);
  end
endmodule : fet_sensor_model

//--- test/fet_timing_gen_tb.sv
// self-checking bench for the fine-edge timing generator
`timescale 1ns/10ps
module fet_timing_gen_tb
  import fet_pkg::*;
;
  logic        ref_clk_i    = 1'b0;
  logic        resetn_i     = 1'b0;
  logic        ser_clk_i    = 1'b0;
  logic        ser_data_i   = 1'b0;
  logic        ser_load_n_i = 1'b1;
  logic [11:0] adc          = 12'h000;
  logic        gate, gate_oe, ha, ha_oe, hai, hai_oe, hb, hb_oe, hbi, hbi_oe, ref_s, dat_s, odp, d_oe, clamp, gain;
  logic [2:0]  ha_drv, hai_drv, hb_drv, hbi_drv, gate_drv, steer;
  logic [1:0]  pwr;
  logic [11:0] dout;
  logic [15:0] shifts, resets, s0, r0;
  logic [47:0] v_ha, v_gate, v_hb, v_ref, v_dat, v_odp;
  int          bad_count, samples_checked, cycles, n;

  fet_timing_gen fet_timing_gen_i (
    .ref_clk_i, .resetn_i, .ser_clk_i, .ser_data_i, .ser_load_n_i, .adc_data_i(adc),
    .reset_gate_pulse_o(gate), .reset_gate_pulse_oe_o(gate_oe), .horiz_clock_a_o(ha), .horiz_clock_a_oe_o(ha_oe),
    .horiz_clock_a_inv_o(hai), .horiz_clock_a_inv_oe_o(hai_oe), .horiz_clock_b_o(hb), .horiz_clock_b_oe_o(hb_oe),
    .horiz_clock_b_inv_o(hbi), .horiz_clock_b_inv_oe_o(hbi_oe), .horiz_a_drive_o(ha_drv),
    .horiz_a_inv_drive_o(hai_drv), .horiz_b_drive_o(hb_drv), .horiz_b_inv_drive_o(hbi_drv),
    .reset_gate_drive_o(gate_drv), .reference_sample_strobe_o(ref_s), .data_sample_strobe_o(dat_s),
    .output_data_phase_o(odp), .data_o(dout), .data_oe_o(d_oe), .power_mode_o(pwr), .clamp_disable_o(clamp),
    .colour_steer_o(steer), .gain_steer_en_o(gain)
  );
  fet_sensor_model fet_sensor_model_i (
    .ref_clk_i, .ha_i(ha), .ha_oe_i(ha_oe), .gate_i(gate), .gate_oe_i(gate_oe), .shifts_o(shifts),
    .resets_o(resets)
  );

  // master clock runs at 48 times the pixel clock
  always #20 ref_clk_i = ~ref_clk_i;
  // converter data moves every cycle
  always @(posedge ref_clk_i)
    #1 adc = adc + 12'h001;
  // cycle ceiling against a hung run
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    if (bad_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask : tick

  // serial frame, lsb first; a full 16-bit frame commits on the load rise
  task automatic frame(input logic [15:0] bits, input int nb);
    ser_load_n_i = 1'b0;
    for (int i = 0; i < nb; i++)
    begin
      ser_data_i = bits[i];
      ser_clk_i  = 1'b0;
      tick(1);
      ser_clk_i = 1'b1;
      tick(1);
    end
    ser_clk_i = 1'b0;
    tick(1);
    ser_load_n_i = 1'b1;
    tick(3);
  endtask : frame

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    frame({d, a}, 16);
  endtask : wr

  function automatic logic [47:0] span(input int r, input int f);
    for (int k = 0; k < 48; k++)
      span[k] = (r <= f) ? (k >= r && k < f) : (k >= r || k < f);
  endfunction : span

  // one period of clocks a and b, reset gate and the three strobes, aligned to the clock a rise
  task automatic measure();
    logic p;
    p = 1'b1;
    tick(100);
    for (int i = 0; i < 60 && !(ha === 1'b1 && p === 1'b0); i++)
    begin
      p = ha;
      tick(1);
    end
    for (int k = 0; k < 48; k++)
    begin
      {v_ha[k], v_gate[k], v_hb[k], v_ref[k], v_dat[k], v_odp[k]} = {ha, gate, hb, ref_s, dat_s, odp};
      tick(1);
    end
  endtask : measure

  task automatic count_changes();
    logic [11:0] p;
    n = 0;
    p = dout;
    repeat (48)
    begin
      tick(1);
      if (dout !== p)
        n++;
      p = dout;
    end
  endtask : count_changes

  task automatic defaults();
    check("drive", {ha_drv, hai_drv, hb_drv, hbi_drv, gate_drv}, 15'h36DA);
    check("enables", {gate_oe, ha_oe, hai_oe, hb_oe, hbi_oe}, 5'h1F);
    measure();
    check("clock a", v_ha, span(0, 24));
    check("reset gate", v_gate, span(0, 12));
    check("ref strobe", v_ref, 48'h1 << 28);
    check("data strobe", v_dat, 48'h1);
    check("clock b", v_hb, span(0, 24));
    check("out phase", v_odp, 48'h1);
  endtask : defaults

  // main sequence
  initial
  begin
    tick(16);
    resetn_i = 1'b1;
    tick(2);
    defaults();
    s0 = shifts;
    r0 = resets;
    tick(480);
    check("shifts", shifts - s0, 16'h000A);
    check("gate pulses", resets - r0, 16'h000A);
    // edge codes keep offsets within 0..11
    wr(FET_A_GATE_POS, 8'h05);
    wr(FET_A_GATE_NEG, 8'h31);
    wr(FET_A_HA_NEG, 8'h2B);
    wr(FET_A_HB_POS, 8'h10);
    wr(FET_A_HB_NEG, 8'h30);
    wr(FET_A_HB_POL, 8'h01);
    wr(FET_A_REF_LOC, 8'h1B);
    wr(FET_A_DAT_LOC, 8'h3B);
    wr(FET_A_DOUT_PHASE, 8'h2F);
    measure();
    check("clock a", v_ha, span(0, 35));
    check("reset gate", v_gate, span(5, 37));
    check("clock b", v_hb, ~span(12, 36));
    check("ref strobe", v_ref, 48'h1 << 23);
    check("data strobe", v_dat, 48'h1 << 47);
    check("out phase", v_odp, 48'h1 << 47);
    wr(FET_A_HA_POS, 8'h02);
    wr(FET_A_HA_POL, 8'h01);
    wr(FET_A_GATE_POL, 8'h01);
    measure();
    check("clock a", v_ha, span(0, 15));
    check("reset gate", v_gate, ~span(18, 2));
    check("ref strobe", v_ref, 48'h1 << 36);
    for (logic [2:0] m = 0; m < 4; m++)
    begin
      wr(FET_A_OPMODE_LO, {3'h0, 1'b1, 1'b0, m[0], m[1:0]});
      check("power", pwr, m[1:0]);
      check("clamp", clamp, m[0]);
    end
    wr(FET_A_OPMODE_HI, 8'h00);
    check("power", pwr, 2'h3);
    for (logic [3:0] c = 0; c < 8; c++)
    begin
      wr(FET_A_CTL_MODE, {2'h0, c[1], 1'b0, c[0], c[2:0]});
      check("steer", steer, c[2:0]);
      check("gain", gain, c[0]);
      check("data enable", d_oe, !c[1]);
    end
    wr(FET_A_CTL_MODE, 8'h00);
    count_changes();
    check("latched", n, 1);
    wr(FET_A_CTL_MODE, 8'h10);
    count_changes();
    check("transparent", n, 48);
    wr(FET_A_HA_DRV, 8'h00);
    wr(FET_A_GATE_DRV, 8'h07);
    wr(8'h07, 8'h00);
    frame({8'h00, FET_A_GATE_DRV}, 15);
    check("drive", {ha_drv, gate_drv, ha_oe, gate_oe}, 8'h1D);
    wr(FET_A_HAI_DRV, 8'h00);
    wr(FET_A_HB_DRV, 8'h06);
    wr(FET_A_HBI_DRV, 8'h01);
    check("drive all", {ha_drv, hai_drv, hb_drv, hbi_drv, gate_drv}, 15'h018F);
    check("enables", {gate_oe, ha_oe, hai_oe, hb_oe, hbi_oe}, 5'h13);
    resetn_i = 1'b0;
    tick(4);
    resetn_i = 1'b1;
    tick(2);
    check("power", {pwr, clamp}, 3'h0);
    defaults();
    complete_run();
  end
endmodule : fet_timing_gen_tb
